// *** verilog/tsp_pkg.sv ***
package tsp_pkg;
  // Trace stream shape
  localparam int TRACE_W = 4;
  localparam int FIFO_DEPTH = 8;
  // Scan port sizes
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int DBG_W = 8;
  // Instruction codes
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_DBG_CTRL = 4'h8;
  localparam logic [IR_W-1:0] IR_DBG_STAT = 4'h9;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
  // Arbitrary identity value, no meaning
  localparam logic [DR_W-1:0] ID_CODE_DEFAULT = 32'h0abc_de01;
  // Data register lengths
  localparam int LEN_BYPASS = 1;
  localparam int LEN_DBG = DBG_W;
  localparam int LEN_ID = DR_W;
  // Debug control fields
  localparam int CTRL_BREAK_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  // Reset values
  localparam logic [DBG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h6;
  localparam logic PIN_IDLE = 1'b1;
  // Scan clock ceiling in MHz
  localparam int SCAN_MAX_MHZ = 33;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'ha,
    TAP_SHIFT_IR = 4'hb,
    TAP_EXIT1_IR = 4'hc,
    TAP_PAUSE_IR = 4'hd,
    TAP_EXIT2_IR = 4'he,
    TAP_UPD_IR = 4'hf
  } tsp_tap_type;
endpackage

// *** verilog/tsp_fifo.sv ***
`timescale 1ns/1ps
module tsp_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // Drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != DEPTH_C);
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// *** verilog/tsp_port.sv ***
`timescale 1ns/1ps
// Functional notes
// - Every trace code from execution leaves on the 4-bit trace bus, one nibble per trace clock.
// - The packet-last output is high on the final nibble of every trace packet.
// - A packet is one or more consecutive nibbles and the capture side gathers them until packet-last.
// - The trace clock output runs at the system clock's frequency and phase.
// - The shared pin selects reset mode while cold reset is held and becomes break/trigger afterwards.
// - The tristate test input floats every output pin for board test.
// - A boundary-scan port with scan clock, mode select, serial in and serial out is provided.
// - Serial in and mode select are sampled on each rising scan clock edge.
// - Serial out changes on the falling scan clock edge.
// - The scan clock is at most 33 MHz and asynchronous, so every crossing is synchronised.
module tsp_port #(
  parameter logic [tsp_pkg::DR_W-1:0] ID_CODE = tsp_pkg::ID_CODE_DEFAULT,
  parameter int TRACE_DEPTH = tsp_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Board level pins
  input wire logic power_on_reset_n_i,
  input wire logic tristate_i,
  // Trace codes from the core
  input wire logic [tsp_pkg::TRACE_W-1:0] trace_code_i,
  input wire logic trace_last_i,
  input wire logic trace_valid_i,
  output logic trace_ready_o,
  // Trace pins
  output logic [tsp_pkg::TRACE_W-1:0] trace_nibble_bus_o,
  output logic trace_packet_last_o,
  output logic trace_nibble_valid_o,
  output logic trace_capture_clock_o,
  output logic trace_pins_oe_n_o,
  // Shared reset-mode / break pin
  input wire logic break_trigger_pin_n_i,
  output logic break_trigger_pin_n_o,
  output logic break_trigger_pin_n_oe_n_o,
  // Debug configuration and core side
  input wire logic brk_pin_output_i,
  input wire logic brk_pin_trigger_i,
  input wire logic break_request_i,
  input wire logic trigger_fire_i,
  output logic reset_mode_select_n_o,
  output logic cold_reset_active_o,
  output logic break_in_o,
  output logic trigger_in_o,
  output logic scan_break_o,
  // Scan port
  input wire logic scan_clock_i,
  input wire logic scan_mode_select_i,
  input wire logic scan_serial_in_i,
  output logic scan_serial_out_o,
  output logic scan_serial_out_oe_n_o
);
  import tsp_pkg::*;

  localparam int FW = TRACE_W + 1;

  // Pin synchronisers: bit 0 cold reset, 1 tristate, 2 shared pin
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_f_q;
  logic [2:0] pin_f_d;
  logic cold_n;
  logic tri_on;
  logic pin_lvl;
  logic pin_lvl_prev_q;

  // Trace path
  logic [FW-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_ready;
  logic [TRACE_W-1:0] nibble_q;
  logic last_q;
  logic nvalid_q;
  logic trace_oe_n_q;

  // Shared pin and core side
  logic reset_mode_q;
  logic brk_out_q;
  logic brk_oe_n_q;
  logic break_in_q;
  logic trig_in_q;
  logic scan_brk_q;

  // Control word from scan domain
  logic [2:0] tgl_s_q;
  logic tgl_seen_q;
  logic tgl_event;
  logic [DBG_W-1:0] ctrl_sys_q;
  logic trace_hold;

  // Scan domain
  tsp_tap_type tap_q;
  tsp_tap_type tap_d;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_sr_q;
  logic [DR_W-1:0] dr_sr_q;
  logic [DR_W-1:0] dr_shift;
  logic [DBG_W-1:0] ctrl_scan_q;
  logic ctrl_tgl_q;
  logic [DBG_W-1:0] stat_s1_q;
  logic [DBG_W-1:0] stat_s2_q;
  logic [DBG_W-1:0] stat_word;
  logic tdo_q;
  logic tdo_oe_n_q;

  function automatic tsp_tap_type tap_next(input tsp_tap_type s, input logic tms);
    case (s)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      default: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  function automatic int dr_len(input logic [IR_W-1:0] ir);
    if (ir == IR_IDCODE) begin
      dr_len = LEN_ID;
    end else if (ir == IR_DBG_CTRL || ir == IR_DBG_STAT) begin
      dr_len = LEN_DBG;
    end else begin
      dr_len = LEN_BYPASS;
    end
  endfunction

  // ---------------- System clock domain ----------------

  // A change counts only once the second and third stage agree
  assign pin_f_d = (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
  assign cold_n = pin_f_q[0];
  assign tri_on = pin_f_q[1];
  assign pin_lvl = pin_f_q[2];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= PIN_SYNC_RESET;
      pin_s2_q <= PIN_SYNC_RESET;
      pin_s3_q <= PIN_SYNC_RESET;
      pin_f_q <= PIN_SYNC_RESET;
    end else begin
      pin_s1_q <= {break_trigger_pin_n_i, tristate_i, power_on_reset_n_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end

  // Trace buffer; the core stalls on trace_ready_o when it fills
  tsp_fifo #(
    .WIDTH(FW),
    .DEPTH(TRACE_DEPTH)
  ) u_trace_fifo (
    .clk_i(mclk_i),
    .rst_i(rst_i),
    .in_data_i({trace_last_i, trace_code_i}),
    .in_valid_i(trace_valid_i),
    .in_ready_o(trace_ready_o),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  // Drain stalls while isolated, in cold reset or held from the scan port
  assign trace_hold = ctrl_sys_q[CTRL_HOLD_BIT];
  assign fifo_ready = cold_n & ~tri_on & ~trace_hold;

  // One nibble per cycle, launched on the rising edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nibble_q <= '0;
      last_q <= 1'b0;
      nvalid_q <= 1'b0;
    end else if (fifo_valid && fifo_ready) begin
      nibble_q <= fifo_out[TRACE_W-1:0];
      last_q <= fifo_out[TRACE_W];
      nvalid_q <= 1'b1;
    end else begin
      last_q <= 1'b0;
      nvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trace_oe_n_q <= 1'b1;
    end else begin
      trace_oe_n_q <= tri_on;
    end
  end

  assign trace_nibble_bus_o = nibble_q;
  assign trace_packet_last_o = last_q;
  assign trace_nibble_valid_o = nvalid_q;
  assign trace_pins_oe_n_o = trace_oe_n_q;
  // Forwarded clock cannot come from a flop and keep the same rate
  assign trace_capture_clock_o = mclk_i;

  // Reset mode follows the pin only while cold reset is held
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_mode_q <= PIN_IDLE;
    end else if (!cold_n) begin
      reset_mode_q <= pin_lvl;
    end
  end

  // Break/trigger role starts only after cold reset release
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_out_q <= PIN_IDLE;
      brk_oe_n_q <= 1'b1;
    end else if (!cold_n || tri_on || !brk_pin_output_i) begin
      brk_out_q <= PIN_IDLE;
      brk_oe_n_q <= 1'b1;
    end else begin
      brk_oe_n_q <= 1'b0;
      if (brk_pin_trigger_i) begin
        brk_out_q <= ~trigger_fire_i;
      end else begin
        brk_out_q <= ~(break_request_i | scan_brk_q);
      end
    end
  end

  // Falling pin edge in input role reports a break or a trigger
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_lvl_prev_q <= PIN_IDLE;
      break_in_q <= 1'b0;
      trig_in_q <= 1'b0;
    end else begin
      pin_lvl_prev_q <= pin_lvl;
      break_in_q <= 1'b0;
      trig_in_q <= 1'b0;
      if (cold_n && !brk_pin_output_i && pin_lvl_prev_q && !pin_lvl) begin
        break_in_q <= ~brk_pin_trigger_i;
        trig_in_q <= brk_pin_trigger_i;
      end
    end
  end

  // Toggle from the scan domain, three stages like the board pins
  assign tgl_event = (tgl_s_q[1] == tgl_s_q[2]) && (tgl_s_q[2] != tgl_seen_q);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_s_q <= '0;
      tgl_seen_q <= 1'b0;
      ctrl_sys_q <= CTRL_RESET;
      scan_brk_q <= 1'b0;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], ctrl_tgl_q};
      scan_brk_q <= 1'b0;
      if (tgl_event) begin
        // Word has stood still for several cycles by now
        tgl_seen_q <= tgl_s_q[2];
        ctrl_sys_q <= ctrl_scan_q;
        scan_brk_q <= ctrl_scan_q[CTRL_BREAK_BIT];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_mode_select_n_o <= PIN_IDLE;
      cold_reset_active_o <= 1'b1;
      break_in_o <= 1'b0;
      trigger_in_o <= 1'b0;
      scan_break_o <= 1'b0;
    end else begin
      reset_mode_select_n_o <= reset_mode_q;
      cold_reset_active_o <= ~cold_n;
      break_in_o <= break_in_q;
      trigger_in_o <= trig_in_q;
      scan_break_o <= scan_brk_q;
    end
  end

  assign break_trigger_pin_n_o = brk_out_q;
  assign break_trigger_pin_n_oe_n_o = brk_oe_n_q;

  // ---------------- Scan clock domain ----------------

  // Quasi-static status levels, two stages each
  always_ff @(posedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      stat_s1_q <= '0;
      stat_s2_q <= '0;
    end else begin
      stat_s1_q <= {3'h0, trace_hold, fifo_valid, tri_on, reset_mode_q, cold_n};
      stat_s2_q <= stat_s1_q;
    end
  end
  assign stat_word = stat_s2_q;

  assign tap_d = tap_next(tap_q, scan_mode_select_i);

  always_ff @(posedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      tap_q <= TAP_RESET;
    end else begin
      tap_q <= tap_d;
    end
  end

  always_ff @(posedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      ir_sr_q <= '0;
      ir_q <= IR_IDCODE;
    end else begin
      case (tap_q)
        TAP_RESET: ir_q <= IR_IDCODE;
        TAP_CAP_IR: ir_sr_q <= IR_CAPTURE_VAL;
        TAP_SHIFT_IR: ir_sr_q <= {scan_serial_in_i, ir_sr_q[IR_W-1:1]};
        TAP_UPD_IR: ir_q <= ir_sr_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  // Serial in enters at the top of the selected register's length
  always_comb begin
    dr_shift = {1'b0, dr_sr_q[DR_W-1:1]};
    dr_shift[dr_len(ir_q)-1] = scan_serial_in_i;
  end

  always_ff @(posedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      dr_sr_q <= '0;
    end else if (tap_q == TAP_CAP_DR) begin
      if (ir_q == IR_IDCODE) begin
        dr_sr_q <= ID_CODE;
      end else if (ir_q == IR_DBG_STAT) begin
        dr_sr_q <= {{(DR_W-DBG_W){1'b0}}, stat_word};
      end else if (ir_q == IR_DBG_CTRL) begin
        dr_sr_q <= {{(DR_W-DBG_W){1'b0}}, ctrl_scan_q};
      end else begin
        dr_sr_q <= '0;
      end
    end else if (tap_q == TAP_SHIFT_DR) begin
      dr_sr_q <= dr_shift;
    end
  end

  // Control word stays put until the next update, so one toggle suffices
  always_ff @(posedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_scan_q <= CTRL_RESET;
      ctrl_tgl_q <= 1'b0;
    end else if (tap_q == TAP_UPD_DR && ir_q == IR_DBG_CTRL) begin
      ctrl_scan_q <= dr_sr_q[DBG_W-1:0];
      ctrl_tgl_q <= ~ctrl_tgl_q;
    end
  end

  // Serial out launched on the falling edge; tristate reaches it via status sync
  always_ff @(negedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q <= (tap_q == TAP_SHIFT_IR) ? ir_sr_q[0] : dr_sr_q[0];
      tdo_oe_n_q <= ~(((tap_q == TAP_SHIFT_IR) || (tap_q == TAP_SHIFT_DR)) && !stat_s2_q[2]);
    end
  end

  assign scan_serial_out_o = tdo_q;
  assign scan_serial_out_oe_n_o = tdo_oe_n_q;
endmodule

// *** verification/tsp_checker.sv ***
`timescale 1ns/1ps
module tsp_checker (
  // Clocks and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scan_clock_i,
  // Inputs watched
  input wire logic tristate_i,
  input wire logic brk_pin_output_i,
  input wire logic brk_pin_trigger_i,
  input wire logic break_request_i,
  input wire logic trigger_fire_i,
  // Outputs watched
  input wire logic trace_packet_last_o,
  input wire logic trace_nibble_valid_o,
  input wire logic trace_capture_clock_o,
  input wire logic trace_pins_oe_n_o,
  input wire logic break_trigger_pin_n_o,
  input wire logic break_trigger_pin_n_oe_n_o,
  input wire logic reset_mode_select_n_o,
  input wire logic cold_reset_active_o,
  input wire logic break_in_o,
  input wire logic trigger_in_o,
  input wire logic scan_serial_out_o
);
  logic tdo_rise_q;
  sequence s_tri_held;
    tristate_i [*6];
  endsequence
  sequence s_out_role(trg);
    !cold_reset_active_o && brk_pin_output_i && brk_pin_trigger_i == trg;
  endsequence
  // Serial out seen at the rising edge, to prove it holds through the high phase
  always_ff @(posedge scan_clock_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_rise_q <= 1'b0;
    end else begin
      tdo_rise_q <= scan_serial_out_o;
    end
  end
  AST_LAST_QUAL: assert property (@(posedge mclk_i) disable iff (rst_i)
    trace_packet_last_o |-> trace_nibble_valid_o) else $error("packet end without nibble");
  AST_CLK_FWD: assert property (@(negedge mclk_i) disable iff (rst_i)
    trace_capture_clock_o) else $error("trace clock not in phase");
  AST_TRI_FLOAT: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_tri_held |-> trace_pins_oe_n_o && break_trigger_pin_n_oe_n_o) else $error("pins driven in tristate");
  AST_COLD_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
    cold_reset_active_o [*2] |-> break_trigger_pin_n_oe_n_o) else $error("shared pin driven in cold reset");
  AST_MODE_FREEZE: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cold_reset_active_o [*3] |-> $stable(reset_mode_select_n_o)) else $error("reset mode moved");
  AST_BRK_OUT: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_out_role(1'b0) ##0 break_request_i |=> !break_trigger_pin_n_o) else $error("break not driven");
  AST_TRG_OUT: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_out_role(1'b1) |=> break_trigger_pin_n_o == !$past(trigger_fire_i)) else $error("trigger level wrong");
  AST_BRK_IN: assert property (@(posedge mclk_i) disable iff (rst_i)
    break_in_o |-> !brk_pin_output_i && !brk_pin_trigger_i ##1 !break_in_o) else $error("break in wrong");
  AST_TRG_IN: assert property (@(posedge mclk_i) disable iff (rst_i)
    trigger_in_o |-> !brk_pin_output_i && brk_pin_trigger_i ##1 !trigger_in_o) else $error("trigger in wrong");
  AST_TDO_FALL: assert property (@(negedge scan_clock_i) disable iff (rst_i)
    scan_serial_out_o == tdo_rise_q) else $error("serial out moved on rising edge");
endmodule

// *** verification/tsp_probe.sv ***
`timescale 1ns/1ps
module tsp_probe (
  // Trace capture side
  input wire logic trc_clk_i,
  input wire logic [tsp_pkg::TRACE_W-1:0] trc_data_i,
  input wire logic trc_last_i,
  input wire logic trc_valid_i,
  input wire logic trc_oe_n_i,
  // Scan side
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  logic [tsp_pkg::TRACE_W:0] got_q[$];
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // Capture on the edge opposite the launch edge
  always @(negedge trc_clk_i) begin
    if (trc_valid_i && !trc_oe_n_i) begin
      got_q.push_back({trc_last_i, trc_data_i});
    end
  end
  // Clock only inside frames, 80 ns period, below the ceiling
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #40 tck_o = 1'b1;
    tdo = tdo_i;
    #40 tck_o = 1'b0;
  endtask
  task automatic tap_reset();
    logic b;
    // Offset keeps scan edges off the system clock's rising edges
    #13.3;
    repeat (5) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b1, b);
  endtask
  // From idle through one shift and back to idle, LSB first
  task automatic shift(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, 1'b0, b);
    if (ir) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    tick(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule

// *** verification/tb_trace_and_scan_test_port.sv ***
`timescale 1ns/1ps
module tb_trace_and_scan_test_port;
  import tsp_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, power_on_reset_n_i = 1'b0, tristate_i = 1'b0, pin_drv_n = 1'b0;
  logic [TRACE_W-1:0] trace_code_i = 4'h0, trace_nibble_bus_o;
  logic trace_last_i = 1'b0, trace_valid_i = 1'b0, brk_pin_output_i = 1'b0, brk_pin_trigger_i = 1'b0;
  logic break_request_i = 1'b0, trigger_fire_i = 1'b0;
  logic trace_ready_o, trace_packet_last_o, trace_nibble_valid_o, trace_capture_clock_o, trace_pins_oe_n_o;
  logic break_trigger_pin_n_o, break_trigger_pin_n_oe_n_o, reset_mode_select_n_o, cold_reset_active_o;
  logic break_in_o, trigger_in_o, scan_break_o, scan_clock_i, scan_mode_select_i, scan_serial_in_i;
  logic scan_serial_out_o, scan_serial_out_oe_n_o;
  int fail_count = 0, compares = 0;
  // Shared pin and serial out both have pull-ups on the board
  wire logic break_trigger_pin_n_i = pin_drv_n & (break_trigger_pin_n_oe_n_o | break_trigger_pin_n_o);
  wire logic tdo_line = scan_serial_out_oe_n_o | scan_serial_out_o;
  always #2.5 mclk_i = ~mclk_i;
  tsp_port u_tsp_port (.mclk_i, .rst_i, .power_on_reset_n_i, .tristate_i, .trace_code_i, .trace_last_i,
    .trace_valid_i, .trace_ready_o, .trace_nibble_bus_o, .trace_packet_last_o, .trace_nibble_valid_o,
    .trace_capture_clock_o, .trace_pins_oe_n_o, .break_trigger_pin_n_i, .break_trigger_pin_n_o,
    .break_trigger_pin_n_oe_n_o, .brk_pin_output_i, .brk_pin_trigger_i, .break_request_i, .trigger_fire_i,
    .reset_mode_select_n_o, .cold_reset_active_o, .break_in_o, .trigger_in_o, .scan_break_o, .scan_clock_i,
    .scan_mode_select_i, .scan_serial_in_i, .scan_serial_out_o, .scan_serial_out_oe_n_o);
  tsp_probe u_tsp_probe (.trc_clk_i(trace_capture_clock_o), .trc_data_i(trace_nibble_bus_o),
    .trc_last_i(trace_packet_last_o), .trc_valid_i(trace_nibble_valid_o), .trc_oe_n_i(trace_pins_oe_n_o),
    .tck_o(scan_clock_i), .tms_o(scan_mode_select_i), .tdi_o(scan_serial_in_i), .tdo_i(tdo_line));
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_level(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 50) begin
      @(negedge mclk_i);
      n++;
    end
    chk_bit(s, v);
  endtask
  task automatic cold_start();
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk_i);
      power_on_reset_n_i <= 1'b0;
      pin_drv_n <= m[0];
      repeat (10) @(posedge mclk_i);
      power_on_reset_n_i <= 1'b1;
      wait_level(cold_reset_active_o, 1'b0);
      chk_bit(reset_mode_select_n_o, m[0]);
      @(posedge mclk_i) pin_drv_n <= ~m[0];
      repeat (8) @(negedge mclk_i);
      chk_bit(reset_mode_select_n_o, m[0]);
    end
    @(posedge mclk_i) pin_drv_n <= 1'b1;
  endtask
  // Packets of 1, 3, 3 and 3 nibbles; buffer fills while pins float
  task automatic trace_fill();
    @(posedge mclk_i) tristate_i <= 1'b1;
    repeat (8) @(negedge mclk_i);
    chk_bit(trace_pins_oe_n_o, 1'b1);
    chk_bit(break_trigger_pin_n_oe_n_o, 1'b1);
    @(posedge mclk_i);
    for (int i = 0; i < 10; i++) begin
      if (i == 8) begin
        @(negedge mclk_i);
        chk_bit(trace_ready_o, 1'b0);
        @(posedge mclk_i) tristate_i <= 1'b0;
      end
      trace_code_i <= i[3:0];
      trace_last_i <= (i % 3 == 0);
      trace_valid_i <= 1'b1;
      do @(posedge mclk_i); while (trace_ready_o !== 1'b1);
    end
    trace_valid_i <= 1'b0;
    repeat (30) @(negedge mclk_i);
    chk_bit(trace_pins_oe_n_o, 1'b0);
    chk_word(32'(u_tsp_probe.got_q.size()), 32'd10);
    for (int k = 0; k < 10; k++) begin
      chk_word(32'(u_tsp_probe.got_q[k]), 32'({(k % 3 == 0), k[3:0]}));
    end
  endtask
  task automatic pin_roles();
    @(posedge mclk_i);
    brk_pin_output_i <= 1'b1;
    break_request_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_bit(break_trigger_pin_n_oe_n_o, 1'b0);
    chk_bit(break_trigger_pin_n_i, 1'b0);
    @(posedge mclk_i);
    brk_pin_trigger_i <= 1'b1;
    break_request_i <= 1'b0;
    repeat (3) @(negedge mclk_i);
    chk_bit(break_trigger_pin_n_i, 1'b1);
    @(posedge mclk_i) trigger_fire_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk_bit(break_trigger_pin_n_i, 1'b0);
    @(posedge mclk_i) trigger_fire_i <= 1'b0;
    for (int t = 0; t < 2; t++) begin
      @(posedge mclk_i);
      brk_pin_output_i <= 1'b0;
      brk_pin_trigger_i <= t[0];
      repeat (8) @(posedge mclk_i);
      pin_drv_n <= 1'b0;
      if (t == 0) begin
        wait_level(break_in_o, 1'b1);
      end else begin
        wait_level(trigger_in_o, 1'b1);
      end
      @(posedge mclk_i) pin_drv_n <= 1'b1;
    end
  endtask
  task automatic scan_test();
    logic [31:0] d;
    logic brk_seen;
    u_tsp_probe.tap_reset();
    u_tsp_probe.shift(1'b1, 32'(IR_IDCODE), IR_W, d);
    chk_word(d, 32'(IR_CAPTURE_VAL));
    u_tsp_probe.shift(1'b0, 32'h0, DR_W, d);
    chk_word(d, ID_CODE_DEFAULT);
    u_tsp_probe.shift(1'b1, 32'(IR_BYPASS), IR_W, d);
    u_tsp_probe.shift(1'b0, 32'h1, 2, d);
    chk_word(d, 32'h2);
    u_tsp_probe.shift(1'b1, 32'(IR_DBG_CTRL), IR_W, d);
    // Break pulse lands before the shift returns, so watch alongside it
    brk_seen = 1'b0;
    fork
      u_tsp_probe.shift(1'b0, 32'h1, LEN_DBG, d);
      repeat (260) begin
        @(negedge mclk_i);
        brk_seen = brk_seen | scan_break_o;
      end
    join
    chk_bit(brk_seen, 1'b1);
    chk_word(d, 32'(CTRL_RESET));
    u_tsp_probe.shift(1'b0, 32'h2, LEN_DBG, d);
    chk_word(d, 32'h1);
    @(posedge mclk_i);
    trace_code_i <= 4'ha;
    trace_last_i <= 1'b1;
    trace_valid_i <= 1'b1;
    @(posedge mclk_i) trace_valid_i <= 1'b0;
    repeat (20) @(negedge mclk_i);
    chk_word(32'(u_tsp_probe.got_q.size()), 32'd10);
    u_tsp_probe.shift(1'b0, 32'h0, LEN_DBG, d);
    chk_word(d, 32'h2);
    repeat (20) @(negedge mclk_i);
    chk_word(32'(u_tsp_probe.got_q[10]), 32'h1a);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    cold_start();
    trace_fill();
    pin_roles();
    scan_test();
    complete_run();
  end
  // Whole run needs well under 30 us
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule
bind tsp_port tsp_checker u_tsp_checker (.mclk_i, .rst_i, .scan_clock_i, .tristate_i, .brk_pin_output_i,
  .brk_pin_trigger_i, .break_request_i, .trigger_fire_i, .trace_packet_last_o, .trace_nibble_valid_o,
  .trace_capture_clock_o, .trace_pins_oe_n_o, .break_trigger_pin_n_o, .break_trigger_pin_n_oe_n_o,
  .reset_mode_select_n_o, .cold_reset_active_o, .break_in_o, .trigger_in_o, .scan_serial_out_o);
